//--- rtl/dfp_pkg.sv
// Package of constants for the data flash partition controller
package dfp_pkg;
    localparam logic [7:0] DFP_RUNTIME_ADDR = 8'h9C;
    localparam logic [7:0] DFP_SFR_BASE = 8'h80;
    localparam logic [7:0] DFP_CFG0_RESET = 8'hFF;
    localparam logic [7:0] DFP_CFG1_RESET = 8'hFF;
    localparam int DFP_DF_ENABLE_N_BIT = 0;
    localparam logic [7:0] DFP_LOW_BYTE = 8'h00;
    localparam logic [7:0] DFP_ALL_DATA = 8'h00;
    localparam logic [3:0] DFP_BIT_NIB_A = 4'h0;
    localparam logic [3:0] DFP_BIT_NIB_B = 4'h8;
    localparam int DFP_FLASH_AW = 16;
    typedef enum logic [2:0] {
        DFP_LOAD = 3'b001,
        DFP_RUN = 3'b010,
        DFP_HOLD = 3'b100
    } dfp_state_e;
endpackage

//--- rtl/dfp_map_if.sv
// Interface carrying the partition map between the two modules
`timescale 1ns/1ps
interface dfp_map_if;
    logic enable_n;
    logic [7:0] start_high;
    logic [15:0] flash_addr;
    logic is_data;
    logic no_code;
    modport ctrl (output enable_n, output start_high, output flash_addr,
        input is_data, input no_code);
    modport dec (input enable_n, input start_high, input flash_addr,
        output is_data, output no_code);
endinterface

//--- rtl/dfp_region_dec.sv
// Region decoder: classifies a flash address as data flash or code
`timescale 1ns/1ps
module dfp_region_dec
    import dfp_pkg::*;
(
    dfp_map_if.dec m
);
    wire [15:0] start_addr;
    wire enabled;
    // R3: low byte fixed
    assign start_addr = {m.start_high, DFP_LOW_BYTE};
    // R8: start ignored unless enabled
    assign enabled = ~m.enable_n;
    // R1: R2: R17: boundary compare
    assign m.is_data = enabled && (m.flash_addr >= start_addr);
    // R7: zero start leaves no code
    assign m.no_code = enabled && (m.start_high == DFP_ALL_DATA);
endmodule

//--- rtl/dfp_ctrl.sv
// Data flash partition controller top module
//
// Functional notes
// R1: Enable bit 1 gives no data flash; whole 64k is code.
// R2: Enable bit 0 splits flash at the runtime start-address register.
// R3: Start address is runtime byte as high byte, low byte zero.
// R4: Every reset loads runtime register from configuration start byte.
// R5: Writing the runtime register moves the boundary at once.
// R6: Runtime register write accepted only after timed-access unlock.
// R7: Start byte zero: all data flash, no code, fetch externally.
// R8: Start bytes only honoured while data flash enable bit is 0.
// R9: Data flash reached only through in-system programming operations.
// R10: In-system programming disabled while executing external code.
// R11: Software must program enable bit to 0 before data flash use.
// R12: Configuration bytes read all ones while unprogrammed.
// R13: Runtime register decoded at special-function address 9CH.
// R14: Special registers at 80H-FFH, direct addressing only.
// R15: Bit access only where address low nibble is 0H or 8H.
// R16: Software leaves unassigned special addresses untouched.
// R17: Addresses at or above start are data flash, below are code.
`timescale 1ns/1ps
module dfp_ctrl
    import dfp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CFG_PROGRAMMED_I,
    input wire logic [7:0] CFG0_I,
    input wire logic [7:0] CFG1_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic SFR_DIRECT_I,
    input wire logic SFR_BIT_I,
    input wire logic [2:0] SFR_BITSEL_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic GUARD_OPEN_I,
    input wire logic EXT_EXEC_I,
    input wire logic PROG_REQ_I,
    input wire logic CPU_FETCH_I,
    input wire logic [15:0] FLASH_ADDR_I,
    output logic [7:0] SFR_RDATA_O,
    output logic SFR_HIT_O,
    output logic [7:0] CFG0_O,
    output logic [7:0] CFG1_O,
    output logic [15:0] DF_START_O,
    output logic DF_PRESENT_O,
    output logic EXT_FETCH_O,
    output logic PROG_ALLOW_O,
    output logic FLASH_IS_DATA_O,
    output logic FLASH_GRANT_O
);
    ////////////////////////////////////////////////////////////////////
    dfp_map_if map ();
    dfp_state_e state_r, state_nxt;
    logic [7:0] runtime_r, runtime_nxt;
    logic [7:0] cfg0_eff, cfg1_eff;
    wire sfr_space, direct_ok, reg_sel, bit_ok, wr_ok, rd_ok;
    wire [7:0] bit_merged;

    function automatic logic [7:0] set_bit(input logic [7:0] v,
        input logic [2:0] sel, input logic b);
        logic [7:0] r;
        r = v;
        r[sel] = b;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // R12: unprogrammed bytes read as all ones
    always_comb begin
        cfg0_eff = CFG_PROGRAMMED_I ? CFG0_I : DFP_CFG0_RESET;
        cfg1_eff = CFG_PROGRAMMED_I ? CFG1_I : DFP_CFG1_RESET;
    end

    // R14: direct addressing to upper range only
    assign sfr_space = SFR_ADDR_I >= DFP_SFR_BASE;
    assign direct_ok = sfr_space && SFR_DIRECT_I;
    // R13: single byte decode
    assign reg_sel = direct_ok && (SFR_ADDR_I == DFP_RUNTIME_ADDR);
    // R15: bit access on 0H or 8H nibble only
    assign bit_ok = !SFR_BIT_I || (SFR_ADDR_I[3:0] == DFP_BIT_NIB_A)
        || (SFR_ADDR_I[3:0] == DFP_BIT_NIB_B);
    // R6: timed-access guard gates writes
    assign wr_ok = SFR_WR_I && reg_sel && bit_ok && GUARD_OPEN_I
        && (state_r == DFP_RUN);
    assign rd_ok = SFR_RD_I && reg_sel && bit_ok;
    assign bit_merged = SFR_BIT_I ?
        set_bit(runtime_r, SFR_BITSEL_I, SFR_WDATA_I[0]) : SFR_WDATA_I;

    ////////////////////////////////////////////////////////////////////
    // R4: copy configuration byte after reset
    always_comb begin
        state_nxt = state_r;
        runtime_nxt = runtime_r;
        case (state_r)
            DFP_LOAD: begin
                runtime_nxt = cfg1_eff;
                state_nxt = DFP_RUN;
            end
            DFP_RUN: begin
                // R5: write moves boundary at once
                if (wr_ok) begin
                    runtime_nxt = bit_merged;
                end
            end
            DFP_HOLD: begin
                state_nxt = DFP_RUN;
            end
            default: begin
                state_nxt = DFP_LOAD;
            end
        endcase
    end

    // Reset takes a constant; the strap is caught on the first edge after
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= DFP_LOAD;
            runtime_r <= DFP_CFG1_RESET;
        end else begin
            state_r <= state_nxt;
            runtime_r <= runtime_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // R8: enable bit qualifies the start byte
    assign map.enable_n = cfg0_eff[DFP_DF_ENABLE_N_BIT];
    assign map.start_high = runtime_r;
    assign map.flash_addr = FLASH_ADDR_I;

    dfp_region_dec u_dec (
        .m(map)
    );

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SFR_RDATA_O <= 8'h00;
        end else if (rd_ok) begin
            SFR_RDATA_O <= runtime_r;
        end
    end

    assign SFR_HIT_O = reg_sel && bit_ok && (SFR_RD_I || SFR_WR_I);
    assign CFG0_O = cfg0_eff;
    assign CFG1_O = cfg1_eff;
    // R1: R2: start reported only when split active
    assign DF_START_O = map.enable_n ? {DFP_FLASH_AW{1'b1}}
        : {runtime_r, DFP_LOW_BYTE};
    assign DF_PRESENT_O = ~map.enable_n;
    // R7: no code space forces external fetch
    assign EXT_FETCH_O = map.no_code;
    // R10: no programming from external code
    assign PROG_ALLOW_O = !EXT_EXEC_I && !map.no_code;
    assign FLASH_IS_DATA_O = map.is_data;
    // R9: R17: only programming path reaches data
    assign FLASH_GRANT_O = map.is_data ? (PROG_REQ_I && PROG_ALLOW_O)
        : (CPU_FETCH_I || (PROG_REQ_I && PROG_ALLOW_O));
endmodule

//--- verification/dfp_core_model.sv
// Core-side model that opens the timed-access guard
`timescale 1ns/1ps
module dfp_core_model (
    input wire logic clk_i,
    input wire logic unlock_i,
    output logic guard_open_o = 1'b0
);
    // guard open for the one cycle after unlock, the cycle of the write
    always @(posedge clk_i) guard_open_o <= unlock_i;
endmodule

//--- verification/dfp_ctrl_props.sv
// Checker for the data flash partition controller ports
`timescale 1ns/1ps
module dfp_ctrl_props (
    input wire logic CLK_I, RSTN_I, SFR_WR_I, SFR_DIRECT_I, SFR_BIT_I,
    input wire logic GUARD_OPEN_I, EXT_EXEC_I, PROG_REQ_I,
    input wire logic [7:0] SFR_ADDR_I, SFR_WDATA_I, CFG0_O, CFG1_O,
    input wire logic [15:0] FLASH_ADDR_I, DF_START_O,
    input wire logic DF_PRESENT_O, EXT_FETCH_O, PROG_ALLOW_O,
    input wire logic FLASH_IS_DATA_O, FLASH_GRANT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    chk_off_map: assert property (CFG0_O[0] |->
        DF_START_O == 16'hFFFF && !DF_PRESENT_O) else $error("map on");
    chk_low_zero: assert property (DF_PRESENT_O |->
        DF_START_O[7:0] == 8'h00) else $error("low byte set");
    chk_ext_fetch: assert property (EXT_FETCH_O ==
        (DF_PRESENT_O && DF_START_O[15:8] == 8'h00)) else $error("ext");
    chk_prog_off: assert property (EXT_EXEC_I |-> !PROG_ALLOW_O &&
        !(FLASH_IS_DATA_O && FLASH_GRANT_O)) else $error("prog on");
    chk_data_path: assert property (FLASH_IS_DATA_O && !PROG_REQ_I
        |-> !FLASH_GRANT_O) else $error("data granted");
    chk_region_split: assert property (DF_PRESENT_O |->
        FLASH_IS_DATA_O == (FLASH_ADDR_I >= DF_START_O)) else $error("split");
    chk_write_moves: assert property ($past(RSTN_I) && SFR_WR_I &&
        GUARD_OPEN_I && SFR_DIRECT_I && !SFR_BIT_I && SFR_ADDR_I == 8'h9C &&
        DF_PRESENT_O |=> DF_START_O[15:8] == $past(SFR_WDATA_I))
        else $error("write lost");
    chk_guard_shut: assert property ($past(RSTN_I) && SFR_WR_I &&
        !GUARD_OPEN_I |=> $stable(DF_START_O)) else $error("guard ignored");
    chk_reset_load: assert property (!$past(RSTN_I) && !CFG0_O[0]
        |=> DF_START_O[15:8] == $past(CFG1_O)) else $error("no load");
endmodule
bind dfp_ctrl dfp_ctrl_props u_props (.*);

//--- verification/tb_top.sv
// Self-checking bench for the data flash partition controller
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rstn = 0, prog = 0, we = 0, rd = 0, dir = 1, bt = 0;
    logic ext = 0, prg = 0, cpu = 0, unl = 0, guard, hit, pres, xf;
    logic ia, isd, gr;
    logic [7:0] c0 = 8'hFF, c1 = 8'hFF, addr = 8'h00, wd = 8'h00;
    logic [7:0] rdat, c0o, c1o;
    logic [15:0] fa = 16'h0000, dfs;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    dfp_ctrl uut (.CLK_I(clk), .RSTN_I(rstn), .CFG_PROGRAMMED_I(prog),
        .CFG0_I(c0), .CFG1_I(c1), .SFR_WR_I(we), .SFR_RD_I(rd),
        .SFR_DIRECT_I(dir), .SFR_BIT_I(bt), .SFR_BITSEL_I(3'h0),
        .SFR_ADDR_I(addr), .SFR_WDATA_I(wd), .GUARD_OPEN_I(guard),
        .EXT_EXEC_I(ext), .PROG_REQ_I(prg), .CPU_FETCH_I(cpu),
        .FLASH_ADDR_I(fa), .SFR_RDATA_O(rdat), .SFR_HIT_O(hit),
        .CFG0_O(c0o), .CFG1_O(c1o), .DF_START_O(dfs), .DF_PRESENT_O(pres),
        .EXT_FETCH_O(xf), .PROG_ALLOW_O(ia), .FLASH_IS_DATA_O(isd),
        .FLASH_GRANT_O(gr));
    dfp_core_model core (.clk_i(clk), .unlock_i(unl), .guard_open_o(guard));
    initial forever #4 clk = ~clk;
    // Whole run needs about 60 cycles
    always @(posedge clk) if (++cyc == 3000) begin
        n_mismatch++;
        end_of_test();
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic p, input logic [7:0] a, b);
        rstn = 0;
        prog = p;
        c0 = a;
        c1 = b;
        repeat (8) @(posedge clk);
        #1 rstn = 1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Unlock is raised one cycle ahead, so the write lands in the guard window
    // only the assigned address is ever written
    task automatic sfr_wr(input logic [7:0] a, d, input logic t, r, b);
        @(posedge clk) #1 unl = t;
        @(posedge clk) #1 unl = 0;
        {we, addr, wd, dir, bt} = {1'b1, a, d, r, b};
        #1 chk(hit, r && !b && a == 8'h9C);
        @(posedge clk) #1 {we, dir, bt} = 3'b010;
    endtask
    task automatic sfr_rd(input logic [7:0] exp);
        @(posedge clk) #1 {rd, addr} = {1'b1, 8'h9C};
        #1 chk(hit, 1'b1);
        @(posedge clk) #1 rd = 0;
        @(posedge clk) #1 chk(rdat, exp);
    endtask
    initial begin
        rst(0, 8'h00, 8'h00);
        chk({c0o, c1o}, 16'hFFFF);
        chk({pres, dfs}, 17'h0FFFF);
        $display("test 1 done");
        rst(1, 8'hFE, 8'h80);
        chk(dfs, 16'h8000);
        sfr_rd(8'h80);
        {fa, cpu} = {16'h7FFF, 1'b1};
        #1 chk({isd, gr}, 2'b01);
        fa = 16'h8000;
        #1 chk({isd, gr}, 2'b10);
        prg = 1;
        #1 chk(gr, 1'b1);
        ext = 1;
        #1 chk({ia, gr}, 2'b00);
        {ext, cpu, prg} = 3'b000;
        $display("test 2 done");
        sfr_wr(8'h9C, 8'h40, 1, 1, 0);
        chk(dfs, 16'h4000);
        sfr_rd(8'h40);
        sfr_wr(8'h9C, 8'h20, 0, 1, 0);
        sfr_wr(8'h9C, 8'h20, 1, 0, 0);
        sfr_wr(8'h9C, 8'h21, 1, 1, 1);
        chk(dfs, 16'h4000);
        sfr_wr(8'h9C, 8'h00, 1, 1, 0);
        chk(xf, 1'b1);
        $display("test 3 done");
        rst(1, 8'hFE, 8'h00);
        chk({xf, ia, dfs}, 18'h20000);
        rst(1, 8'hFF, 8'h00);
        chk({xf, pres, dfs}, 18'h0FFFF);
        $display("test 4 done");
        end_of_test();
    end
endmodule
